// File: design/snc_config_bank.sv
/*
 * Configuration line bank of the current sensor: eighteen 16-bit lines
 * written and read one line at a time by the programming interface,
 * a reload sequencer that checks the checksum and applies the fields,
 * and the two open-drain over-current detection outputs.
 * Assumes the line port is driven from logic on core_clk; trip and
 * fault levels come from the analog side and are synchronised here.
 */
// Operation
// - Channel-two enable gates only over-current detection
// - Line 41 bits 1:0 channel-one hysteresis
// - Line 41 bits 7:2 channel-one threshold
// - Line 41 bits 9:8 channel-two hysteresis
// - Line 41 bits 15:10 channel-two threshold
// - Line 42 low byte holds content checksum
// - Line 42 bits 10:8 reference, single-ended only
// - Line 42 bit 11 inverts output polarity
// - Line 42 bit 12 enables 1.5 V quiescent
// - Line 42 bit 13 removes fault from channel one
// - Line 42 bit 14 enables ratiometric gain
// - Line 42 bit 15 enables ratiometric offset
// - Eleven-bit gain base assembled from three lines
// - Signed gain temperature coefficients in three lines
// - Line 45 bits 3:0 stress base low
// - Line 48 signed offset and stress base
// - Line 49 signed offset and stress coefficients
// - Checksum mismatch flags error, pulls both outputs
// - Checksum polynomial, seed, byte order, inversion
// - Lines are individually addressable 16-bit words
`timescale 1ns/1ns
`default_nettype none

module snc_config_bank
   import snc_pkg::*;
#(
   parameter bit PKG_VARIANT_B = 1'b0   // Selects the channel-two threshold default
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                line_wr,
   input  wire logic                line_rd,
   input  wire logic [7:0]          line_addr,
   input  wire logic [LINE_W-1:0]   line_wdata,
   output logic [LINE_W-1:0]        line_rdata,
   output logic                     line_rvalid,
   input  wire logic                reload_req,
   output logic                     reload_busy,
   input  wire logic                trip1_in,
   input  wire logic                trip2_in,
   input  wire logic                fault_in,
   output logic                     safety_error,
   output snc_cfg_t                 cfg,
   output logic                     ocd1_out,
   output logic                     ocd1_oe_n,
   output logic                     ocd2_out,
   output logic                     ocd2_oe_n
);

   // Channel-two threshold default depends on the package
   localparam logic [5:0] DEF_CH2_THRESH = PKG_VARIANT_B ? DEF_CH2_THR_B : DEF_CH2_THR_A;

   logic [LINE_W-1:0] mem_q [LINE_COUNT];   // Line storage
   logic [IDX_W-1:0]  wr_idx;               // Index of the addressed line
   logic              addr_ok;              // Address falls inside the bank
   logic [LINE_W-1:0] rdata_d, rdata_q;     // Read data
   logic              rvalid_q;             // Read answer strobe
   snc_state_t        state_d, state_q;     // Reload sequencer state
   logic [5:0]        cnt_d, cnt_q;         // Checksum byte counter, 35 bytes need six bits
   logic [7:0]        crc_d, crc_q;         // Running checksum
   logic [7:0]        crc_final;            // Inverted checksum after last byte
   logic              err_d, err_q;         // Checksum mismatch flag
   snc_cfg_t          cfg_d, cfg_q;         // Applied configuration
   logic [1:0]        t1_s;                 // Channel-one trip synchroniser
   logic [1:0]        t2_s;                 // Channel-two trip synchroniser
   logic [1:0]        f_s;                  // Fault synchroniser
   logic              pull1_d, pull2_d;     // Pull-low requests
   logic              oe1_n_q, oe2_n_q;     // Registered output enables
   logic [4:0]        byte_line;            // Line that supplies the current byte
   logic [7:0]        cur_byte;             // Byte fed into the checksum

   // One checksum step over a full byte, MSB first
   // The loop unrolls into a fixed XOR network, so one byte costs one cycle
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int b = 0; b < 8; b++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_step

   // Address decode, index is the offset from the first line
   // The base has zero low bits, so the subtraction folds to a plain slice
   assign wr_idx  = line_addr[IDX_W-1:0] - LINE_BASE[IDX_W-1:0];
   assign addr_ok = (line_addr >= LINE_BASE) && (line_addr < LINE_BASE + 8'(LINE_COUNT));

   // Line storage; each line is written whole, no partial writes
   // Reset restores the defaults; lines without one clear to zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < LINE_COUNT; i++) begin
            mem_q[i] <= '0;
         end
         mem_q[IDX_L40] <= 16'h0000 | (16'h0001 << POS_CH1_EN) | (16'h0001 << POS_CH2_EN);
         mem_q[IDX_L41] <= {DEF_CH2_THRESH, DEF_HYST, DEF_CH1_THRESH, DEF_HYST};
         mem_q[IDX_L42] <= {8'h00, 5'h00, DEF_VREF} << 8;
      end else if (line_wr && addr_ok) begin
         mem_q[wr_idx] <= line_wdata;
      end
   end

   // Read path, unmapped lines answer zero
   // The index wraps outside the bank, so addr_ok must guard the mux
   always_comb begin
      rdata_d = addr_ok ? mem_q[wr_idx] : '0;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= line_rd ? rdata_d : rdata_q;
         rvalid_q <= line_rd;
      end
   end

   // Byte order: lines 43..51 then 40..42, high byte first
   // The pass covers all eighteen lines, 35 bytes at one byte per cycle;
   // lines written during a pass may mix old and new bytes, so the
   // programmer should finish its writes before asking for a reload
   always_comb begin
      byte_line = 5'(cnt_q[5:1]) + IDX_L43;
      if (byte_line >= 5'(LINE_COUNT)) begin
         byte_line = byte_line - 5'(LINE_COUNT);
      end
      cur_byte = cnt_q[0] ? mem_q[byte_line][7:0] : mem_q[byte_line][15:8];
   end

   assign crc_final = ~crc_step(crc_q, cur_byte);

   // Reload sequencer; fields reach cfg only when the pass completes,
   // so a half-written set of lines never steers the front end
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      crc_d   = crc_q;
      err_d   = err_q;
      cfg_d   = cfg_q;
      unique case (state_q)
         SNC_IDLE: begin
            // A request during a pass is dropped, not queued
            if (reload_req) begin
               state_d = SNC_CALC;
               cnt_d   = '0;
               crc_d   = CRC_SEED;
            end
         end
         SNC_CALC: begin
            crc_d = crc_step(crc_q, cur_byte);
            cnt_d = cnt_q + 6'h01;
            // Last byte: verdict and every field land in the same cycle
            if (cnt_q == CRC_LAST) begin
               state_d = SNC_IDLE;
               err_d   = (crc_final != mem_q[IDX_L42][7:0]);
               cfg_d.ch1_enable                = mem_q[IDX_L40][POS_CH1_EN];
               cfg_d.ch2_enable                = mem_q[IDX_L40][POS_CH2_EN];
               cfg_d.ch1_hysteresis            = mem_q[IDX_L41][1:0];
               cfg_d.ch1_threshold             = mem_q[IDX_L41][7:2];
               cfg_d.ch2_hysteresis            = mem_q[IDX_L41][9:8];
               cfg_d.ch2_threshold             = mem_q[IDX_L41][15:10];
               cfg_d.external_reference_select = mem_q[IDX_L42][10:8];
               cfg_d.output_polarity_invert    = mem_q[IDX_L42][POS_POL_INV];
               cfg_d.quiescent_1v5_enable      = mem_q[IDX_L42][POS_QV_1V5];
               cfg_d.ch1_fault_signal_disable  = mem_q[IDX_L42][POS_CH1_FDIS];
               cfg_d.ratiometric_gain_enable   = mem_q[IDX_L42][POS_RATIO_GAIN];
               cfg_d.ratiometric_offset_enable = mem_q[IDX_L42][POS_RATIO_OFF];
               cfg_d.gain_base = {mem_q[IDX_L45][POS_GBASE_MSB], mem_q[IDX_L44][5:0],
                                  mem_q[IDX_L43][3:0]};
               cfg_d.gain_tc_linear    = signed'(mem_q[IDX_L43][15:4]);
               cfg_d.gain_tc_quadratic = signed'(mem_q[IDX_L44][15:6]);
               cfg_d.gain_tc_cubic     = signed'(mem_q[IDX_L45][15:5]);
               cfg_d.stress_base_low   = mem_q[IDX_L45][3:0];
               cfg_d.offset_base       = signed'(mem_q[IDX_L48][7:0]);
               cfg_d.stress_base       = signed'(mem_q[IDX_L48][15:8]);
               cfg_d.offset_tc_linear  = signed'(mem_q[IDX_L49][7:0]);
               cfg_d.stress_tc_linear  = signed'(mem_q[IDX_L49][15:8]);
            end
         end
      endcase
   end

   // Reset starts a reload at once, as a power-up load would
   // cfg stays zero until then, so trips are ignored for the first pass
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= SNC_CALC;
         cnt_q   <= '0;
         crc_q   <= CRC_SEED;
         err_q   <= 1'b0;
         cfg_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         crc_q   <= crc_d;
         err_q   <= err_d;
         cfg_q   <= cfg_d;
      end
   end

   // Pull-low decision; the enables gate trips only, faults bypass them
   // err_q bypasses every mask: a corrupt bank must never look healthy
   always_comb begin
      pull1_d = (t1_s[1] && cfg_q.ch1_enable) || (f_s[1] && !cfg_q.ch1_fault_signal_disable)
                || err_q;
      pull2_d = (t2_s[1] && cfg_q.ch2_enable) || f_s[1] || err_q;
   end

   // Synchronisers and output enables; stage 0 may be metastable,
   // so logic reads only stage 1, the second flip-flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         t1_s    <= '0;
         t2_s    <= '0;
         f_s     <= '0;
         oe1_n_q <= 1'b1;
         oe2_n_q <= 1'b1;
      end else begin
         t1_s    <= {t1_s[0], trip1_in};
         t2_s    <= {t2_s[0], trip2_in};
         f_s     <= {f_s[0], fault_in};
         oe1_n_q <= !pull1_d;
         oe2_n_q <= !pull2_d;
      end
   end

   assign line_rdata   = rdata_q;
   assign line_rvalid  = rvalid_q;
   assign reload_busy  = (state_q == SNC_CALC);
   assign safety_error = err_q;
   assign cfg          = cfg_q;
   // Open-drain pins only ever drive low; the enables do the work
   assign ocd1_out     = 1'b0;
   assign ocd2_out     = 1'b0;
   assign ocd1_oe_n    = oe1_n_q;
   assign ocd2_oe_n    = oe2_n_q;

   // Checks; a pass lasts 35 cycles, one per checksum byte
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_ch2_gate_trip: assert property (t2_s[1] && !cfg_q.ch2_enable && !f_s[1] && !err_q |=> ocd2_oe_n)
      else $error("channel two pulled low while disabled");
   chk_ch2_fault_pass: assert property (f_s[1] |=> !ocd2_oe_n)
      else $error("fault not signalled on channel two");
   chk_ch1_fault_mask: assert property (f_s[1] && cfg_q.ch1_fault_signal_disable && !t1_s[1] && !err_q
      |=> ocd1_oe_n)
      else $error("fault reached channel one while masked");
   chk_err_pins_low: assert property (err_q |=> !ocd1_oe_n && !ocd2_oe_n)
      else $error("checksum error did not pull outputs low");
   chk_crc_verdict: assert property (state_q == SNC_CALC && cnt_q == CRC_LAST
      |=> err_q == ($past(crc_final) != $past(mem_q[IDX_L42][7:0])))
      else $error("checksum verdict wrong");
   chk_reload_length: assert property (state_q == SNC_CALC && cnt_q == 6'h00 |-> ##34 reload_busy ##1 !reload_busy)
      else $error("checksum pass length wrong");
   chk_cfg_hold_idle: assert property (state_q == SNC_IDLE |=> $stable(cfg_q))
      else $error("configuration changed outside a reload");
   chk_gain_base_map: assert property (state_q == SNC_CALC && cnt_q == CRC_LAST
      |=> cfg_q.gain_base == {$past(mem_q[IDX_L45][4]), $past(mem_q[IDX_L44][5:0]), $past(mem_q[IDX_L43][3:0])})
      else $error("gain base assembled wrongly");
   chk_line_write: assert property (line_wr && addr_ok |=> mem_q[$past(wr_idx)] == $past(line_wdata))
      else $error("line write lost");
   chk_read_answer: assert property (line_rd |=> line_rvalid && line_rdata == $past(rdata_d))
      else $error("read answer missing or wrong");
   chk_busy_hold: assert property (reload_busy && cnt_q != CRC_LAST |=> reload_busy && $stable(cfg_q))
      else $error("pass ended early or applied fields too soon");
   chk_ch2_trip_pass: assert property (t2_s[1] && cfg_q.ch2_enable |=> !ocd2_oe_n)
      else $error("enabled channel two trip not signalled");
   chk_ch1_fault_pass: assert property (f_s[1] && !cfg_q.ch1_fault_signal_disable |=> !ocd1_oe_n)
      else $error("fault not signalled on channel one");
   chk_err_hold: assert property (err_q && state_q == SNC_IDLE |=> err_q)
      else $error("checksum error cleared outside a reload");

   // Field map at the end of a pass
   chk_thresh_map: assert property (state_q == SNC_CALC && cnt_q == CRC_LAST
      |=> cfg_q.ch1_threshold == $past(mem_q[IDX_L41][7:2]) && cfg_q.ch2_threshold == $past(mem_q[IDX_L41][15:10]))
      else $error("threshold fields mapped wrongly");
   chk_option_map: assert property (state_q == SNC_CALC && cnt_q == CRC_LAST
      |=> {cfg_q.ratiometric_offset_enable, cfg_q.ratiometric_gain_enable, cfg_q.ch1_fault_signal_disable,
           cfg_q.quiescent_1v5_enable, cfg_q.output_polarity_invert, cfg_q.external_reference_select}
          == $past(mem_q[IDX_L42][15:8]))
      else $error("option fields mapped wrongly");
   chk_stress_map: assert property (state_q == SNC_CALC && cnt_q == CRC_LAST
      |=> {cfg_q.stress_base, cfg_q.offset_base} == $past(mem_q[IDX_L48])
          && {cfg_q.stress_tc_linear, cfg_q.offset_tc_linear} == $past(mem_q[IDX_L49]))
      else $error("offset and stress fields mapped wrongly");

   cov_reload_ok: cover property (reload_busy ##1 !reload_busy && !err_q);
   cov_reload_err: cover property (reload_busy ##1 !reload_busy && err_q);
   cov_ch1_trip: cover property (t1_s[1] && cfg_q.ch1_enable ##1 !ocd1_oe_n);
   cov_req_ignored: cover property (reload_busy && reload_req);
   cov_ch1_fault_masked: cover property (f_s[1] && cfg_q.ch1_fault_signal_disable ##1 ocd1_oe_n);

endmodule : snc_config_bank

`default_nettype wire

// File: shared/snc_pkg.sv
/*
 * Shared constants and carriers of the sensor configuration line bank:
 * line addresses, field positions, default field values, checksum
 * constants and the packed configuration record.
 * Assumes a single 250 MHz core clock and 16-bit configuration lines.
 */
package snc_pkg;

   // Line geometry
   localparam int unsigned LINE_W      = 16;      // Bits in one line
   localparam int unsigned LINE_COUNT  = 18;      // Lines covered by the checksum
   localparam logic [7:0]  LINE_BASE   = 8'h40;   // First line address
   localparam int unsigned IDX_W       = 5;       // Width of a line index

   // Line addresses of the bank
   localparam logic [7:0] ADDR_OUTPUT_MODE_CONFIG          = 8'h40;
   localparam logic [7:0] ADDR_OVERCURRENT_THRESHOLD_CONFIG = 8'h41;
   localparam logic [7:0] ADDR_CHECKSUM_AND_REFERENCE_CONFIG = 8'h42;
   localparam logic [7:0] ADDR_GAIN_COEFF_LINEAR           = 8'h43;
   localparam logic [7:0] ADDR_GAIN_COEFF_QUADRATIC        = 8'h44;
   localparam logic [7:0] ADDR_GAIN_COEFF_CUBIC            = 8'h45;
   localparam logic [7:0] ADDR_OFFSET_STRESS_BASE          = 8'h48;
   localparam logic [7:0] ADDR_OFFSET_STRESS_TC_LINEAR     = 8'h49;

   // Line indices relative to the base
   localparam logic [IDX_W-1:0] IDX_L40 = 5'h00;
   localparam logic [IDX_W-1:0] IDX_L41 = 5'h01;
   localparam logic [IDX_W-1:0] IDX_L42 = 5'h02;
   localparam logic [IDX_W-1:0] IDX_L43 = 5'h03;
   localparam logic [IDX_W-1:0] IDX_L44 = 5'h04;
   localparam logic [IDX_W-1:0] IDX_L45 = 5'h05;
   localparam logic [IDX_W-1:0] IDX_L48 = 5'h08;
   localparam logic [IDX_W-1:0] IDX_L49 = 5'h09;

   // Field positions
   localparam int unsigned POS_CH1_EN      = 14;  // Line 40
   localparam int unsigned POS_CH2_EN      = 15;  // Line 40
   localparam int unsigned POS_CH2_EN_CLR  = 15;
   localparam int unsigned POS_POL_INV     = 11;  // Line 42
   localparam int unsigned POS_QV_1V5      = 12;
   localparam int unsigned POS_CH1_FDIS    = 13;
   localparam int unsigned POS_RATIO_GAIN  = 14;
   localparam int unsigned POS_RATIO_OFF   = 15;
   localparam int unsigned POS_GBASE_MSB   = 4;   // Line 45

   // Default field values
   localparam logic [1:0]  DEF_HYST        = 2'h3;
   localparam logic [5:0]  DEF_CH1_THRESH  = 6'h0C;
   localparam logic [5:0]  DEF_CH2_THR_A   = 6'h0F;  // Six-pin package variant
   localparam logic [5:0]  DEF_CH2_THR_B   = 6'h10;  // Sixteen-pin package variant
   localparam logic [2:0]  DEF_VREF        = 3'h0;   // Code for 1.65 V

   // Checksum constants
   localparam logic [7:0]  CRC_POLY        = 8'h1D;
   localparam logic [7:0]  CRC_SEED        = 8'hAA;
   localparam logic [5:0]  CRC_BYTES       = 6'h23;  // 35 bytes, last one is the high byte of line 42
   localparam logic [5:0]  CRC_LAST        = 6'h22;  // Counter value of the last byte

   // Reload sequencer states
   typedef enum logic [0:0] {
      SNC_IDLE = 1'b0,
      SNC_CALC = 1'b1
   } snc_state_t;

   // Configuration record applied after a reload
   typedef struct packed {
      logic               ch1_enable;
      logic               ch2_enable;
      logic [1:0]         ch1_hysteresis;
      logic [5:0]         ch1_threshold;
      logic [1:0]         ch2_hysteresis;
      logic [5:0]         ch2_threshold;
      logic [2:0]         external_reference_select;
      logic               output_polarity_invert;
      logic               quiescent_1v5_enable;
      logic               ch1_fault_signal_disable;
      logic               ratiometric_gain_enable;
      logic               ratiometric_offset_enable;
      logic [10:0]        gain_base;
      logic signed [11:0] gain_tc_linear;
      logic signed [9:0]  gain_tc_quadratic;
      logic signed [10:0] gain_tc_cubic;
      logic [3:0]         stress_base_low;
      logic signed [7:0]  offset_base;
      logic signed [7:0]  stress_base;
      logic signed [7:0]  offset_tc_linear;
      logic signed [7:0]  stress_tc_linear;
   } snc_cfg_t;

endpackage : snc_pkg

// File: test/tb_snc_config_bank.sv
/*
 * Self-checking bench for the sensor configuration line bank: line
 * access, power-up defaults, checksum reload, field mapping and the
 * open-drain over-current outputs.
 * Assumes the bank is the only device on the line port and that the
 * bench plays both the programmer and the analog trip and fault sources.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_snc_config_bank
   import snc_pkg::*;
;
   logic              core_clk;                // 250 MHz core clock
   logic              rst;                     // Asynchronous reset, high
   logic              line_wr;                 // Line write strobe
   logic              line_rd;                 // Line read strobe
   logic [7:0]        line_addr;               // Line address
   logic [LINE_W-1:0] line_wdata;              // Line write data
   logic [LINE_W-1:0] line_rdata;              // Line read data
   logic              line_rvalid;             // Read answer pulse
   logic              reload_req;              // Reload request
   logic              reload_busy;             // Reload in progress
   logic              trip1_in;                // Channel-one comparator
   logic              trip2_in;                // Channel-two comparator
   logic              fault_in;                // Internal fault level
   logic              safety_error;            // Checksum mismatch flag
   snc_cfg_t          cfg;                     // Applied configuration
   logic              ocd1_out;                // Open-drain level, channel one
   logic              ocd1_oe_n;               // Pull-low enable, channel one
   logic              ocd2_out;                // Open-drain level, channel two
   logic              ocd2_oe_n;               // Pull-low enable, channel two
   logic [LINE_W-1:0] mem [LINE_COUNT];        // Expected content of every line
   int                miscompares;             // Mismatches seen
   int                checks;                  // Comparisons made

   snc_config_bank #(.PKG_VARIANT_B(1'b0)) u_snc_config_bank (
      .core_clk(core_clk), .rst(rst), .line_wr(line_wr), .line_rd(line_rd),
      .line_addr(line_addr), .line_wdata(line_wdata), .line_rdata(line_rdata),
      .line_rvalid(line_rvalid), .reload_req(reload_req), .reload_busy(reload_busy),
      .trip1_in(trip1_in), .trip2_in(trip2_in), .fault_in(fault_in),
      .safety_error(safety_error), .cfg(cfg), .ocd1_out(ocd1_out),
      .ocd1_oe_n(ocd1_oe_n), .ocd2_out(ocd2_out), .ocd2_oe_n(ocd2_oe_n)
   );

   // Free-running clock, 4 ns period
   always #2 core_clk = ~core_clk;

   // Compare and report; wide enough for any field of the record
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Single exit of the run
   task automatic end_sim;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   // Reference checksum: line 43 up to the last line, then 40, 41 and the high byte of 42
   function automatic logic [7:0] crc_calc();
      logic [7:0] c;
      logic [7:0] b;
      c = CRC_SEED;
      for (int n = 0; n < 35; n++) begin
         b = (n % 2 == 0) ? mem[(n / 2 + 3) % 18][15:8] : mem[(n / 2 + 3) % 18][7:0];
         c = c ^ b;
         for (int k = 0; k < 8; k++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
         end
      end
      return ~c;
   endfunction : crc_calc

   // One-cycle write strobe, released a full cycle later so calls can follow at once
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      line_wr = 1'b1;
      line_addr = a;
      line_wdata = d;
      @(negedge core_clk);
      line_wr = 1'b0;
   endtask : wr

   // One-cycle read strobe; rvalid pulses for the following cycle only, the read data holds until the next read
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge core_clk);
      line_rd = 1'b1;
      line_addr = a;
      @(negedge core_clk);
      line_rd = 1'b0;
      chk(line_rvalid, 1);
      chk(line_rdata, e);
   endtask : rd

   // Request held for hold cycles: any cycles after the first fall into busy and must be ignored
   task automatic reload(input int hold);
      int busy_n;
      busy_n = 0;
      @(negedge core_clk);
      reload_req = 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(negedge core_clk);
         if (i == hold - 1) begin
            reload_req = 1'b0;
         end
         if (reload_busy === 1'b1) begin
            busy_n++;
         end else if (busy_n > 0) begin
            break;
         end
      end
      chk(busy_n, 35);
      repeat (2) @(negedge core_clk);
      chk(reload_busy, 0);
   endtask : reload

   // Seal the checksum into line 42 and write every line
   task automatic prog;
      mem[2][7:0] = crc_calc();
      for (int i = 0; i < 18; i++) begin
         wr(LINE_BASE + 8'(i), mem[i]);
      end
   endtask : prog

   // Applied record against the field map of the expected lines
   task automatic cfg_check;
      chk({cfg.ch1_enable, cfg.ch2_enable}, {mem[0][14], mem[0][15]});
      chk({cfg.ch1_threshold, cfg.ch1_hysteresis}, mem[1][7:0]);
      chk({cfg.ch2_threshold, cfg.ch2_hysteresis}, mem[1][15:8]);
      chk({cfg.ratiometric_offset_enable, cfg.ratiometric_gain_enable, cfg.ch1_fault_signal_disable,
           cfg.quiescent_1v5_enable, cfg.output_polarity_invert, cfg.external_reference_select},
          mem[2][15:8]);
      chk(cfg.gain_base, {mem[5][4], mem[4][5:0], mem[3][3:0]});
      chk({cfg.gain_tc_linear, cfg.gain_tc_quadratic}, {mem[3][15:4], mem[4][15:6]});
      chk({cfg.gain_tc_cubic, cfg.stress_base_low}, {mem[5][15:5], mem[5][3:0]});
      chk({cfg.stress_base, cfg.offset_base}, mem[8]);
      chk({cfg.stress_tc_linear, cfg.offset_tc_linear}, mem[9]);
      chk({cfg.offset_base < 0, cfg.stress_tc_linear < 0}, {mem[8][7], mem[9][15]});
   endtask : cfg_check

   // Drive trip and fault levels, check the pull-low enables land on the third edge
   task automatic od(input logic t1, input logic t2, input logic f, input logic e1, input logic e2);
      @(negedge core_clk);
      trip1_in = t1;
      trip2_in = t2;
      fault_in = f;
      repeat (2) @(negedge core_clk);
      chk({ocd1_oe_n, ocd2_oe_n}, 2'b11);
      @(negedge core_clk);
      chk({ocd1_oe_n, ocd2_oe_n, ocd1_out, ocd2_out}, {e1, e2, 2'b00});
      trip1_in = 1'b0;
      trip2_in = 1'b0;
      fault_in = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : od

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      miscompares++;
      end_sim();
   end

   // Main sequence
   initial begin
      logic [15:0] p;
      core_clk = 1'b0;
      rst = 1'b1;
      {line_wr, line_rd, reload_req, trip1_in, trip2_in, fault_in} = 6'h00;
      line_addr = 8'h00;
      line_wdata = 16'h0000;
      miscompares = 0;
      checks = 0;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      // Power-up contents, read while the automatic reload runs
      for (int i = 0; i < 18; i++) begin
         mem[i] = 16'h0000;
      end
      mem[0] = 16'hC000;
      mem[1] = 16'h3F33;
      for (int i = 0; i < 18; i++) begin
         rd(LINE_BASE + 8'(i), mem[i]);
      end
      @(negedge core_clk iff reload_busy === 1'b0);
      chk(safety_error, crc_calc() != mem[2][7:0]);
      cfg_check();
      // Places outside the bank ignore writes and read as zero
      wr(8'h52, 16'hFFFF);
      rd(8'h52, 16'h0000);
      rd(8'h3F, 16'h0000);
      // Distinct pattern in every line, sign bits set only in the two line 48 signed fields
      p = 16'h9E35;
      for (int i = 0; i < 18; i++) begin
         mem[i] = p;
         p = p + 16'h2B17;
      end
      mem[0] = 16'hC123;
      mem[2][15:8] = 8'h5B;
      mem[8][7] = 1'b1;
      prog();
      chk(cfg.ch1_threshold, 6'h0C);
      for (int i = 0; i < 18; i++) begin
         rd(LINE_BASE + 8'(i), mem[i]);
      end
      reload(3);
      chk(safety_error, 0);
      cfg_check();
      od(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      od(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      od(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      // Channel two disabled and channel-one fault removed
      mem[0][15] = 1'b0;
      mem[2][13] = 1'b1;
      prog();
      reload(1);
      chk(safety_error, 0);
      cfg_check();
      od(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      od(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      od(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      // One flipped checksum bit pulls both outputs low
      mem[2][7:0] = mem[2][7:0] ^ 8'h01;
      wr(ADDR_CHECKSUM_AND_REFERENCE_CONFIG, mem[2]);
      reload(1);
      chk(safety_error, 1);
      repeat (2) @(negedge core_clk);
      chk({ocd1_oe_n, ocd2_oe_n, ocd1_out, ocd2_out}, 4'h0);
      end_sim();
   end

endmodule : tb_snc_config_bank

`default_nettype wire
